// ==== lvs_cmp_model.sv ====
`timescale 1ns/1ns
`default_nettype none

// Analog comparator and reference model; supply and thresholds are in millivolts.
module lvs_cmp_model #(
    parameter int POC_MV = 2850
) (
    // Controls from the block.
    input  wire logic       i_clk,
    input  wire logic       i_cmp_en,
    input  wire logic       i_ref_en,
    input  wire logic [2:0] i_level_code,
    // Supply level and comparator outputs.
    input  var  int         i_supply_mv,
    output logic            o_poc_below,
    output logic            o_droop_below
);
    logic tog = 1'b0;

    // An idle comparator wanders, so a block that trusts it while disabled is caught.
    always @(posedge i_clk) tog <= ~tog;

    // Threshold falls 200 mV per code from the top level. The reference is ready at
    // once, so the settle wait after enabling it costs nothing here.
    always_comb begin
        o_poc_below   = i_supply_mv < POC_MV;
        o_droop_below = (i_cmp_en && i_ref_en) ? // Runs only when both are on.
            (i_supply_mv < 4300 - 200 * int'(i_level_code)) : tog; // Level.
    end
endmodule // lvs_cmp_model

`default_nettype wire

// ==== lvs_ctrl.sv ====
// Summary of operation
// - Power-on-clear comparator below threshold forces the internal reset.
// - A detector-caused reset sets bit 0 of the reset cause register.
// - Control register takes bit and byte writes; external reset clears it.
// - Bit 0 of the control register is the read-only detection flag.
// - Detector enable bit 7 starts the comparator; clearing it stops detection.
// - With power-on-clear fitted the reference always runs; its enable is ignored.
// - Mode bit 1 picks interrupt at 0 or internal reset at 1.
// - Flag is 1 below threshold, 0 above it or while disabled.
// - Enabled in interrupt mode, the flag drives the interrupt request line.
// - Enable, reference and mode bits survive only the detector's own reset.
// - Level register takes byte writes only; external reset clears it.
// - Level codes 0 to 6 pick 4.3 V down to 3.1 V; 7 prohibited.
// - With 3.5 V power-on-clear, codes 4 to 6 unused; power-on-clear wins.
// - Detector keeps working and acting in stop mode.
`timescale 1ns/1ns
`default_nettype none

`include "lvs_defs.svh"

module lvs_ctrl
    import lvs_pkg::*;
#(
    parameter lvs_poc_opt_t POC_OPTION = LVS_POC_LOW
) (
    // Clock and external reset input.
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    // Other internal reset sources, such as watchdog or clock monitor.
    input  wire logic       i_other_rst,
    // Software clear of the detector reset cause.
    input  wire logic       i_cause_clr,
    // Stop mode indication from the core.
    input  wire logic       i_stop,
    // Register access from the core.
    input  wire lvs_bus_t   i_bus,
    output logic [7:0]      o_rdata,
    // Analog comparators, asynchronous.
    input  wire logic       i_poc_below,
    input  wire logic       i_droop_below,
    // Analog controls.
    output logic            o_cmp_en,
    output logic            o_ref_en,
    output logic [2:0]      o_level_code,
    // Results.
    output logic            o_undervoltage_irq,
    output logic            o_int_rst,
    output logic            o_undervoltage_reset_cause
);

    // Address match, used by both the write and the read paths.
    function automatic logic addr_hit(input logic [15:0] a, input logic [15:0] off);
        addr_hit = (a == off);
    endfunction

    lvs_ctrl_t  ctrl_r;
    lvs_ctrl_t  ctrl_nxt;
    logic [2:0] level_r;
    logic [2:0] level_nxt;
    logic       cause_r;
    logic       cause_nxt;
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;
    logic [1:0] cmp_s;
    logic       poc_s;
    logic       undervoltage_flag;
    logic       droop_rst;
    logic       hit_ctrl;
    logic       hit_level;
    logic [7:0] ctrl_rd;

    // Comparator outputs are asynchronous to the core clock.
    lvs_sync #(
        .WIDTH (2)
    ) u_sync (
        .i_clk   (i_clk),
        .i_async ({i_poc_below, i_droop_below}),
        .o_sync  (cmp_s)
    );

    // Without the power-on-clear option the comparator reads as never tripped.
    assign poc_s = (POC_OPTION != LVS_POC_NONE) && cmp_s[1];

    // Flag and its routing; stop mode gates nothing here, detection runs on.
    assign undervoltage_flag  = ctrl_r.detector_enable && cmp_s[0];
    assign o_undervoltage_irq = undervoltage_flag && !ctrl_r.reset_or_irq_select;
    assign droop_rst          = undervoltage_flag && ctrl_r.reset_or_irq_select;
    assign o_int_rst          = poc_s || droop_rst;

    // Analog controls; the reference is forced on when power-on-clear is fitted.
    assign o_cmp_en     = ctrl_r.detector_enable;
    assign o_ref_en     = (POC_OPTION != LVS_POC_NONE) || ctrl_r.reference_enable;
    assign o_level_code = level_r;
    assign o_undervoltage_reset_cause = cause_r;

    assign hit_ctrl  = addr_hit(i_bus.addr, `LVS_CTRL_ADDR);
    assign hit_level = addr_hit(i_bus.addr, `LVS_LEVEL_ADDR);

    // Control register image; unused bits read zero.
    always_comb begin
        ctrl_rd = 8'h00;
        ctrl_rd[`LVS_DET_EN_BIT] = ctrl_r.detector_enable;
        ctrl_rd[`LVS_REF_EN_BIT] = ctrl_r.reference_enable;
        ctrl_rd[`LVS_MODE_BIT]   = ctrl_r.reset_or_irq_select;
        ctrl_rd[`LVS_FLAG_BIT]   = undervoltage_flag;
    end

    // Control register next value. The detector's own reset is not a clear
    // source, so a droop reset leaves the settings in place and the part
    // comes back up still watching the supply.
    always_comb begin
        ctrl_nxt = ctrl_r;
        if (poc_s || i_other_rst) begin
            ctrl_nxt = '0;
        end else if (hit_ctrl && i_bus.byte_we) begin
            ctrl_nxt.detector_enable     = i_bus.wdata[`LVS_DET_EN_BIT];
            ctrl_nxt.reference_enable    = i_bus.wdata[`LVS_REF_EN_BIT];
            ctrl_nxt.reset_or_irq_select = i_bus.wdata[`LVS_MODE_BIT];
        end else if (hit_ctrl && i_bus.bit_we) begin
            case (i_bus.bit_idx)
                `LVS_DET_EN_BIT: begin
                    ctrl_nxt.detector_enable = i_bus.bit_val;
                end
                `LVS_REF_EN_BIT: begin
                    ctrl_nxt.reference_enable = i_bus.bit_val;
                end
                `LVS_MODE_BIT: begin
                    ctrl_nxt.reset_or_irq_select = i_bus.bit_val;
                end
                default: begin
                    ctrl_nxt = ctrl_r;
                end
            endcase
        end
    end

    // Level register next value. Bit writes are ignored, and the prohibited
    // code is refused so the comparator never sees an undefined tap.
    always_comb begin
        level_nxt = level_r;
        if (poc_s) begin
            level_nxt = `LVS_LEVEL_RST;
        end else if (hit_level && i_bus.byte_we
                     && (i_bus.wdata[2:0] != `LVS_LEVEL_BAD)) begin
            level_nxt = i_bus.wdata[2:0];
        end
    end

    // Reset cause: power-on-clear wipes it; a new detector reset beats a clear.
    always_comb begin
        cause_nxt = cause_r;
        if (poc_s) begin
            cause_nxt = 1'b0;
        end else if (droop_rst) begin
            cause_nxt = 1'b1;
        end else if (i_cause_clr) begin
            cause_nxt = 1'b0;
        end
    end

    // Read data is registered one cycle after the read strobe.
    always_comb begin
        rdata_nxt = rdata_r;
        if (i_bus.rd) begin
            if (hit_ctrl) begin
                rdata_nxt = ctrl_rd;
            end else if (hit_level) begin
                rdata_nxt = {5'h00, level_r};
            end else begin
                rdata_nxt = 8'h00;
            end
        end
    end

    // State registers with the external reset input.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            ctrl_r  <= '0;
            level_r <= `LVS_LEVEL_RST;
            cause_r <= 1'b0;
            rdata_r <= 8'h00;
        end else begin
            ctrl_r  <= ctrl_nxt;
            level_r <= level_nxt;
            cause_r <= cause_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign o_rdata = rdata_r;

    // Checks on the block's own behaviour.
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    sequence s_droop_rst;
        droop_rst && !poc_s;
    endsequence

    property p_poc_rst;
        poc_s |-> o_int_rst;
    endproperty
    a_poc_rst: assert property (p_poc_rst) else $error("poc did not reset");

    property p_cause_set;
        s_droop_rst |=> cause_r
            ##1 (cause_r || $past(poc_s) || $past(i_cause_clr && !droop_rst));
    endproperty
    a_cause_set: assert property (p_cause_set) else $error("cause not set");

    property p_ext_rst;
        disable iff (1'b0) i_rst |=> (ctrl_r == '0) && (level_r == `LVS_LEVEL_RST);
    endproperty
    a_ext_rst: assert property (p_ext_rst) else $error("ext reset missed");

    property p_flag_ro;
        hit_ctrl && i_bus.bit_we && !i_bus.byte_we && (i_bus.bit_idx == `LVS_FLAG_BIT)
            && !poc_s && !i_other_rst |=> $stable(ctrl_r);
    endproperty
    a_flag_ro: assert property (p_flag_ro) else $error("flag bit write had effect");

    property p_flag_off;
        !ctrl_r.detector_enable |-> !undervoltage_flag && !droop_rst && !o_undervoltage_irq;
    endproperty
    a_flag_off: assert property (p_flag_off) else $error("flag set while off");

    property p_irq_route;
        o_undervoltage_irq == (ctrl_r.detector_enable && cmp_s[0]
                               && !ctrl_r.reset_or_irq_select);
    endproperty
    a_irq_route: assert property (p_irq_route) else $error("irq routing wrong");

    property p_keep_on_droop;
        s_droop_rst and (!i_other_rst && !i_bus.byte_we && !i_bus.bit_we)
            |=> $stable(ctrl_r);
    endproperty
    a_keep_on_droop: assert property (p_keep_on_droop) else $error("settings lost");

    property p_other_clr;
        i_other_rst |=> ctrl_r == '0;
    endproperty
    a_other_clr: assert property (p_other_clr) else $error("other reset kept bits");

    property p_level_byte;
        hit_level && i_bus.bit_we && !i_bus.byte_we && !poc_s |=> $stable(level_r);
    endproperty
    a_level_byte: assert property (p_level_byte) else $error("level bit write");

    property p_level_legal;
        level_r != `LVS_LEVEL_BAD;
    endproperty
    a_level_legal: assert property (p_level_legal) else $error("level code 7");

    property p_ref_forced;
        (POC_OPTION != LVS_POC_NONE) |-> o_ref_en;
    endproperty
    a_ref_forced: assert property (p_ref_forced) else $error("reference off");

    property p_sync_lat;
        (POC_OPTION != LVS_POC_NONE) && i_poc_below ##1 i_poc_below |=> o_int_rst;
    endproperty
    a_sync_lat: assert property (p_sync_lat) else $error("sync latency");

endmodule // lvs_ctrl

`default_nettype wire

// ==== lvs_defs.svh ====
`ifndef LVS_DEFS_SVH
`define LVS_DEFS_SVH

// Register addresses in the data space.
`define LVS_CTRL_ADDR   16'hffbe
`define LVS_LEVEL_ADDR  16'hffbf

// Field positions of the detector control register.
`define LVS_DET_EN_BIT  3'h7
`define LVS_REF_EN_BIT  3'h4
`define LVS_MODE_BIT    3'h1
`define LVS_FLAG_BIT    3'h0

// Reset values, the prohibited level code and the lowest code left unused by the 3.5 V power-on-clear.
`define LVS_CTRL_RST    8'h00
`define LVS_LEVEL_RST   3'h0
`define LVS_LEVEL_BAD   3'h7
`define LVS_LEVEL_HIGH0 3'h4

`endif

// ==== lvs_pkg.sv ====
package lvs_pkg;

    // Power-on-clear option fixed at build time.
    typedef enum logic [1:0] {
        LVS_POC_NONE = 2'b00,
        LVS_POC_LOW  = 2'b01,
        LVS_POC_HIGH = 2'b10
    } lvs_poc_opt_t;

    // One register access from the core.
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic        byte_we;
        logic        bit_we;
        logic [2:0]  bit_idx;
        logic        bit_val;
        logic        rd;
    } lvs_bus_t;

    // Writable control bits of the detector control register.
    typedef struct packed {
        logic detector_enable;
        logic reference_enable;
        logic reset_or_irq_select;
    } lvs_ctrl_t;

endpackage

// ==== lvs_sync.sv ====
`timescale 1ns/1ns
`default_nettype none

// Two-flop synchroniser, one lane per comparator output.
module lvs_sync
    import lvs_pkg::*;
#(
    parameter int WIDTH = 2
) (
    // Clock.
    input  wire logic             i_clk,
    // Asynchronous comparator levels.
    input  wire logic [WIDTH-1:0] i_async,
    // Synchronised levels.
    output logic      [WIDTH-1:0] o_sync
);

    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] sync_r;

    // The first stage feeds only the second, so no logic sees a metastable level.
    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : g_lane
            always_ff @(posedge i_clk) begin
                meta_r[g] <= i_async[g];
                sync_r[g] <= meta_r[g];
            end
        end
    endgenerate

    assign o_sync = sync_r;

endmodule // lvs_sync

`default_nettype wire

// ==== tb_low_voltage_supervisor_ctrl.sv ====
`timescale 1ns/1ns
`default_nettype none

`include "lvs_defs.svh"

module tb_low_voltage_supervisor_ctrl
    import lvs_pkg::*;
;
    localparam int POC_MV = 2850;
    // Stimulus, observed ports and model state; supply is in millivolts.
    logic       clk = 1'b0, rst = 1'b1, other_rst = 1'b0, cause_clr = 1'b0, stop = 1'b0;
    lvs_bus_t   bus = '0;
    logic [7:0] rdata, d;
    logic [2:0] code;
    logic       cmp_en, ref_en, irq, int_rst, cause, poc_b, droop_b;
    logic       m_det = 1'b0, m_ref = 1'b0, m_mode = 1'b0, m_cause = 1'b0;
    int         supply = 5000, m_lvl = 0, err_total = 0, total_checks = 0, cyc = 0, k;

    always #5 clk = ~clk;

    lvs_ctrl i_lvs_ctrl (
        .i_clk(clk), .i_rst(rst), .i_other_rst(other_rst), .i_cause_clr(cause_clr),
        .i_stop(stop), .i_bus(bus), .o_rdata(rdata), .i_poc_below(poc_b),
        .i_droop_below(droop_b), .o_cmp_en(cmp_en), .o_ref_en(ref_en), .o_level_code(code),
        .o_undervoltage_irq(irq), .o_int_rst(int_rst), .o_undervoltage_reset_cause(cause)
    );
    lvs_cmp_model #(.POC_MV(POC_MV)) i_lvs_cmp_model (
        .i_clk(clk), .i_cmp_en(cmp_en), .i_ref_en(ref_en), .i_level_code(code),
        .i_supply_mv(supply), .o_poc_below(poc_b), .o_droop_below(droop_b)
    );

    function automatic logic below();
        return m_det && supply < 4300 - 200 * m_lvl;
    endfunction

    task automatic end_of_test();
        $display("Checks %0d, mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: byte %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: bit %b, expected %b", $time, got, exp);
        end
    endtask

    // One request held for exactly one taking edge, then released.
    task automatic bus_op(input logic [15:0] a, input logic [7:0] v, input logic bw,
                          input logic bt, input logic [2:0] ix, input logic r);
        @(posedge clk);
        bus <= '{a, v, bw, bt, ix, v[0], r};
        @(posedge clk);
        bus <= '0;
    endtask

    task automatic rd(input logic [15:0] a, input logic [7:0] exp);
        bus_op(a, 8'h00, 1'b0, 1'b0, 3'h0, 1'b1);
        @(posedge clk);
        #1;
        chk_reg(rdata, exp);
    endtask

    // The model drops refused writes: code 7, and bit writes outside bits 7, 4 and 1.
    task automatic wr(input logic [15:0] a, input logic [7:0] v, input logic bt,
                      input logic [2:0] ix);
        bus_op(a, v, !bt, bt, ix, 1'b0);
        if (a == `LVS_LEVEL_ADDR && !bt && v[2:0] != 3'h7) m_lvl = int'(v[2:0]);
        if (a == `LVS_CTRL_ADDR && !bt) {m_det, m_ref, m_mode} = {v[7], v[4], v[1]};
        if (a == `LVS_CTRL_ADDR && bt && ix == 3'h7) m_det = v[0];
        if (a == `LVS_CTRL_ADDR && bt && ix == 3'h4) m_ref = v[0];
        if (a == `LVS_CTRL_ADDR && bt && ix == 3'h1) m_mode = v[0];
    endtask

    // Three edges cover the two synchroniser flops and the cause register.
    task automatic set_supply(input int mv);
        @(posedge clk);
        supply <= mv;
        repeat (3) @(posedge clk);
        #1;
        if (mv < POC_MV) begin
            {m_det, m_ref, m_mode, m_cause} = 4'h0;
            m_lvl = 0;
        end else if (below() && m_mode) m_cause = 1'b1;
    endtask

    task automatic pulse(input logic which);
        @(posedge clk);
        if (which) other_rst <= 1'b1;
        else cause_clr <= 1'b1;
        @(posedge clk);
        other_rst <= 1'b0;
        cause_clr <= 1'b0;
        if (which) {m_det, m_ref, m_mode} = 3'h0;
        else m_cause = 1'b0;
    endtask

    task automatic do_reset();
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        {m_det, m_ref, m_mode, m_cause} = 4'h0;
        m_lvl = 0;
        repeat (2) @(posedge clk);
    endtask

    task automatic chk_outs();
        repeat (3) @(posedge clk); // Settle before trusting the flag.
        #1;
        chk_bit(irq, below() && !m_mode); // Interrupt line.
        chk_bit(int_rst, supply < POC_MV || below() && m_mode); // Reset.
        chk_bit(cause, m_cause); // Cause flag.
        chk_bit(cmp_en, m_det); // Comparator enable.
        chk_bit(ref_en, 1'b1); // Reference forced on.
        chk_reg({5'h0, code}, 8'(m_lvl)); // Level code.
        rd(`LVS_CTRL_ADDR, {m_det, 2'h0, m_ref, 2'h0, m_mode, below()}); // Flag.
        rd(`LVS_LEVEL_ADDR, 8'(m_lvl)); // Level readback.
    endtask

    // A hang counts as a mismatch and ends the run.
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 8000) begin
            err_total++;
            end_of_test();
        end
    end

    initial begin
        void'($urandom(32'hef53339a));
        do_reset();
        chk_outs(); // Reset values.
        rd(16'h0040, 8'h00); // Unmapped address reads zero.
        $display("reset values done");
        for (k = 0; k < 8; k++) begin
            wr(`LVS_LEVEL_ADDR, 8'(k), 1'b0, 3'h0); // Upper bits zero.
            chk_outs(); // Every code, the prohibited one refused.
        end
        wr(`LVS_LEVEL_ADDR, 8'h01, 1'b1, 3'h0);
        chk_outs(); // Bit write to level is ignored.
        for (k = 0; k < 16; k++) begin
            wr(`LVS_CTRL_ADDR, {7'h0, ~k[3]}, 1'b1, ~k[2:0]); // Enable first.
            chk_outs(); // Bit writes set then clear.
        end
        $display("register access done");
        for (k = 0; k < 60; k++) begin
            set_supply(5000);
            d = 8'($urandom);
            wr(`LVS_CTRL_ADDR, d & 8'hfd, 1'b0, 3'h0); // Interrupt mode first.
            wr(`LVS_CTRL_ADDR, d, 1'b0, 3'h0); // Then the chosen mode.
            wr(`LVS_LEVEL_ADDR, 8'($urandom_range(7)), 1'b0, 3'h0); // Upper bits zero.
            stop <= 1'($urandom);
            set_supply(int'($urandom_range(4500, 2900)));
            chk_outs(); // Random droop, also in stop mode.
        end
        $display("random sweep done");
        set_supply(5000);
        pulse(1'b0);
        wr(`LVS_CTRL_ADDR, 8'h90, 1'b0, 3'h0); // Flag clear before reset mode.
        wr(`LVS_CTRL_ADDR, 8'h92, 1'b0, 3'h0);
        wr(`LVS_LEVEL_ADDR, 8'h03, 1'b0, 3'h0);
        set_supply(3600);
        chk_outs(); // Detector reset keeps settings.
        set_supply(5000);
        pulse(1'b1);
        chk_outs(); // Other reset clears control bits only; level code kept.
        wr(`LVS_CTRL_ADDR, 8'h90, 1'b0, 3'h0); // Flag clear before reset mode.
        wr(`LVS_CTRL_ADDR, 8'h92, 1'b0, 3'h0);
        set_supply(2700);
        chk_outs(); // Power-on-clear reset clears all.
        set_supply(5000);
        wr(`LVS_CTRL_ADDR, 8'h90, 1'b0, 3'h0); // Flag clear before reset mode.
        wr(`LVS_CTRL_ADDR, 8'h92, 1'b0, 3'h0);
        wr(`LVS_CTRL_ADDR, 8'h00, 1'b0, 3'h0); // Stop in one byte write.
        wr(`LVS_LEVEL_ADDR, 8'h05, 1'b0, 3'h0);
        do_reset();
        chk_outs(); // Mid-run external reset.
        $display("reset sources done");
        end_of_test();
    end
endmodule // tb_low_voltage_supervisor_ctrl

`default_nettype wire
